// ---- design/omd_pkg.sv ----
package omd_pkg;
   localparam int ADDR_W = 16;
   localparam int PADDR_W = 8;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PRIO = 8'h3C;
   localparam logic [7:0] IDX_INIT = 8'h3D;
   localparam logic [7:0] IDX_EEPLACE = 8'h3E;
   localparam logic [7:0] IDX_CONFIG = 8'h3F;
   localparam logic [7:0] ADR_PRIO = {IDX_PRIO[5:0], 2'b00};
   localparam logic [7:0] ADR_INIT = {IDX_INIT[5:0], 2'b00};
   localparam logic [7:0] ADR_EEPLACE = {IDX_EEPLACE[5:0], 2'b00};
   localparam logic [7:0] ADR_CONFIG = {IDX_CONFIG[5:0], 2'b00};
   // Field positions
   localparam int CFG_EE_ENABLE = 0;
   localparam int CFG_ROM_PRESENT = 1;
   localparam int CFG_ROM_HIGH = 3;
   localparam int INIT_RAM_LSB = 4;
   localparam int INIT_REG_LSB = 0;
   localparam int EEPLACE_LSB = 4;
   localparam int PRIO_BOOT = 7;
   localparam int PRIO_SMOD = 6;
   localparam int PRIO_MDA = 5;
   // Values after reset
   localparam logic [7:0] INIT_RST = 8'h00;
   localparam logic [7:0] EEPLACE_RST = 8'h00;
   localparam logic [7:0] CONFIG_NV_DEFAULT = 8'h0B;
   // Map offsets within a 4-Kbyte page
   localparam logic [11:0] REG_END = 12'h07F;
   localparam logic [11:0] RAM_SAME_LO = 12'h080;
   localparam logic [11:0] RAM_SAME_END_S = 12'h37F;
   localparam logic [11:0] RAM_SAME_END_L = 12'h47F;
   localparam logic [11:0] RAM_DIFF_END_S = 12'h2FF;
   localparam logic [11:0] RAM_DIFF_END_L = 12'h3FF;
   localparam logic [11:0] EE_LO = 12'hD80;
   // Absolute addresses
   localparam logic [15:0] BOOT_LO = 16'hBE00;
   localparam logic [15:0] BOOT_HI = 16'hBFFF;
   localparam logic [15:0] ROM_S_HIGH_LO = 16'hA000;
   localparam logic [15:0] ROM_S_LOW_LO = 16'h2000;
   localparam logic [15:0] ROM_S_LOW_HI = 16'h7FFF;
endpackage

// ---- design/omd_wr_if.sv ----
`timescale 1ns/1ps
interface omd_wr_if;
   logic wr;
   logic [7:0] wdata;
   logic special;
   logic force_en;
   logic [7:0] force_set;
   logic [7:0] force_clr;
   modport src (output wr, wdata, special, force_en, force_set, force_clr);
   modport dst (input wr, wdata, special, force_en, force_set, force_clr);
endinterface

// ---- design/omd_wonce_reg.sv ----
`timescale 1ns/1ps
module omd_wonce_reg #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic rst_cell,
   omd_wr_if.dst w,
   output logic [7:0] q,
   output logic written
);
   import omd_pkg::*;

   logic [7:0] q_r;
   logic written_r;
   logic take;

   // Normal mode: first write only; special mode: every write
   assign take = w.wr && (w.special || !written_r);

   // Cell content; rst_cell may differ from system reset
   always_ff @(posedge clk_sys or posedge rst_cell) begin
      if (rst_cell) begin
         q_r <= RST_VAL;
      end else if (w.force_en) begin
         q_r <= (q_r | w.force_set) & ~w.force_clr;
      end else if (take) begin
         q_r <= w.wdata;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         written_r <= 1'b0;
      end else if (w.wr) begin
         written_r <= 1'b1;
      end
   end

   assign q = q_r;
   assign written = written_r;

   AST_ONCE_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
      (w.wr && !w.special && written_r && !w.force_en) |=> $stable(q_r))
      else $error("write-once register changed after first write");
endmodule // omd_wonce_reg

// ---- design/omd_map_decoder.sv ----
`timescale 1ns/1ps
module omd_map_decoder #(
   parameter bit LARGE_VARIANT = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic nv_por,
   input wire logic mode_select_a_input,
   input wire logic mode_select_b_input,
   input wire logic [omd_pkg::PADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [omd_pkg::ADDR_W-1:0] cpu_addr,
   output logic sel_regblk,
   output logic sel_ram,
   output logic sel_boot,
   output logic sel_eeprom,
   output logic sel_rom,
   output logic sel_ext
);
   import omd_pkg::*;

   // ------------------------------------------------------------
   // Mode latch
   // ------------------------------------------------------------
   logic latched_r;
   logic force_r;
   logic smod_r;
   logic mda_r;
   logic boot_vis_r;

   // Pins are caught on the first edge after reset release
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         latched_r <= 1'b0;
      end else begin
         latched_r <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         force_r <= 1'b0;
      end else begin
         force_r <= !latched_r;
      end
   end

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   logic setup;
   logic wr_acc;
   logic hit_prio;
   logic hit_init;
   logic hit_eeplace;
   logic hit_cfg;
   logic mapped;
   logic [7:0] rd_mux;
   logic [31:0] prdata_r;
   logic [7:0] init_q;
   logic [7:0] eeplace_q;
   logic [7:0] cfg_q;
   logic [7:0] prio_q;

   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite;
   assign hit_prio = (paddr == ADR_PRIO);
   assign hit_init = (paddr == ADR_INIT);
   assign hit_eeplace = (paddr == ADR_EEPLACE);
   assign hit_cfg = (paddr == ADR_CONFIG);
   assign mapped = hit_prio || hit_init || hit_eeplace || hit_cfg;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   always_comb begin
      rd_mux = 8'h00;
      if (hit_prio) begin
         rd_mux = prio_q;
      end else if (hit_init) begin
         rd_mux = init_q;
      end else if (hit_eeplace) begin
         rd_mux = eeplace_q;
      end else if (hit_cfg) begin
         rd_mux = cfg_q;
      end
   end

   // Read data captured in the setup cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup) begin
         prdata_r <= {24'h00_0000, rd_mux};
      end
   end

   assign prdata = prdata_r;

   // ------------------------------------------------------------
   // Mode bits
   // ------------------------------------------------------------
   // Special mode when mode B low; mode A picks expanded
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         smod_r <= 1'b0;
      end else if (!latched_r) begin
         smod_r <= !mode_select_b_input;
      end else if (wr_acc && hit_prio && !pwdata[PRIO_SMOD]) begin
         smod_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mda_r <= 1'b0;
      end else if (!latched_r) begin
         mda_r <= mode_select_a_input;
      end else if (wr_acc && hit_prio && smod_r) begin
         mda_r <= pwdata[PRIO_MDA];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         boot_vis_r <= 1'b0;
      end else if (!latched_r) begin
         boot_vis_r <= !mode_select_b_input && !mode_select_a_input;
      end else if (!smod_r) begin
         boot_vis_r <= 1'b0;
      end else if (wr_acc && hit_prio) begin
         boot_vis_r <= pwdata[PRIO_BOOT];
      end
   end

   assign prio_q = {boot_vis_r, smod_r, mda_r, 5'b0_0000};

   // ------------------------------------------------------------
   // Placement and option registers
   // ------------------------------------------------------------
   logic single_chip;
   logic test_mode;
   logic [7:0] cfg_set;
   logic [7:0] cfg_clr;

   assign single_chip = !smod_r && !mda_r;
   assign test_mode = smod_r && mda_r;

   always_comb begin
      cfg_set = 8'h00;
      cfg_clr = 8'h00;
      if (single_chip) begin
         cfg_set[CFG_ROM_PRESENT] = 1'b1;
         cfg_set[CFG_ROM_HIGH] = 1'b1;
      end
      if (test_mode) begin
         cfg_clr[CFG_ROM_PRESENT] = 1'b1;
      end
   end

   logic init_done;
   omd_wr_if init_w ();
   omd_wr_if eeplace_w ();
   omd_wr_if cfg_w ();

   assign init_w.wr = wr_acc && hit_init;
   assign init_w.wdata = pwdata[7:0];
   assign init_w.special = smod_r;
   assign init_w.force_en = 1'b0;
   assign init_w.force_set = 8'h00;
   assign init_w.force_clr = 8'h00;

   assign eeplace_w.wr = wr_acc && hit_eeplace;
   assign eeplace_w.wdata = pwdata[7:0];
   assign eeplace_w.special = smod_r;
   assign eeplace_w.force_en = 1'b0;
   assign eeplace_w.force_set = 8'h00;
   assign eeplace_w.force_clr = 8'h00;

   assign cfg_w.wr = wr_acc && hit_cfg;
   assign cfg_w.wdata = pwdata[7:0];
   assign cfg_w.special = smod_r;
   assign cfg_w.force_en = force_r;
   assign cfg_w.force_set = cfg_set;
   assign cfg_w.force_clr = cfg_clr;

   omd_wonce_reg #(.RST_VAL(INIT_RST)) u_init (
      .clk_sys(clk_sys),
      .rst(rst),
      .rst_cell(rst),
      .w(init_w),
      .q(init_q),
      .written(init_done)
   );

   omd_wonce_reg #(.RST_VAL(EEPLACE_RST)) u_eeplace (
      .clk_sys(clk_sys),
      .rst(rst),
      .rst_cell(rst),
      .w(eeplace_w),
      .q(eeplace_q),
      .written()
   );

   // Option cells reset to CONFIG_NV_DEFAULT only by power-on, not by system reset
   omd_wonce_reg #(.RST_VAL(CONFIG_NV_DEFAULT)) u_cfg (
      .clk_sys(clk_sys),
      .rst(rst),
      .rst_cell(nv_por),
      .w(cfg_w),
      .q(cfg_q),
      .written()
   );

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic [3:0] ram_pg;
   logic [3:0] reg_pg;
   logic [3:0] ee_pg;
   logic [3:0] a_pg;
   logic [11:0] a_off;
   logic rom_on;
   logic rom_hi;
   logic ee_on;
   logic hit_reg;
   logic hit_ram;
   logic hit_boot;
   logic hit_ee;
   logic hit_rom;
   logic [11:0] ram_same_end;
   logic [11:0] ram_diff_end;

   assign ram_pg = init_q[INIT_RAM_LSB +: 4];
   assign reg_pg = init_q[INIT_REG_LSB +: 4];
   assign ee_pg = eeplace_q[EEPLACE_LSB +: 4];
   assign a_pg = cpu_addr[15:12];
   assign a_off = cpu_addr[11:0];
   assign rom_on = cfg_q[CFG_ROM_PRESENT];
   assign rom_hi = cfg_q[CFG_ROM_HIGH];
   assign ee_on = cfg_q[CFG_EE_ENABLE];
   assign ram_same_end = LARGE_VARIANT ? RAM_SAME_END_L : RAM_SAME_END_S;
   assign ram_diff_end = LARGE_VARIANT ? RAM_DIFF_END_L : RAM_DIFF_END_S;

   // Placement at reset is page 0 for both; mode plays no part
   assign hit_reg = (a_pg == reg_pg) && (a_off <= REG_END);

   always_comb begin
      hit_ram = 1'b0;
      if (a_pg == ram_pg) begin
         if (ram_pg == reg_pg) begin
            hit_ram = (a_off >= RAM_SAME_LO) && (a_off <= ram_same_end);
         end else begin
            hit_ram = (a_off <= ram_diff_end);
         end
      end
   end

   assign hit_boot = smod_r && boot_vis_r
                  && (cpu_addr >= BOOT_LO) && (cpu_addr <= BOOT_HI);

   // Any page allowed, including the vector page
   assign hit_ee = ee_on && (a_pg == ee_pg) && (a_off >= EE_LO);

   always_comb begin
      hit_rom = 1'b0;
      if (rom_on) begin
         if (LARGE_VARIANT) begin
            hit_rom = rom_hi ? cpu_addr[15] : !cpu_addr[15];
         end else if (rom_hi) begin
            hit_rom = (cpu_addr >= ROM_S_HIGH_LO);
         end else begin
            hit_rom = mda_r && !smod_r && (cpu_addr >= ROM_S_LOW_LO)
                   && (cpu_addr <= ROM_S_LOW_HI);
         end
      end
   end

   // ------------------------------------------------------------
   // Select outputs
   // ------------------------------------------------------------
   logic sel_reg_r;
   logic sel_ram_r;
   logic sel_boot_r;
   logic sel_ee_r;
   logic sel_rom_r;
   logic sel_ext_r;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_reg_r <= 1'b0;
         sel_ram_r <= 1'b0;
         sel_boot_r <= 1'b0;
         sel_ee_r <= 1'b0;
         sel_rom_r <= 1'b0;
         sel_ext_r <= 1'b0;
      end else begin
         sel_reg_r <= hit_reg;
         sel_ram_r <= hit_ram && !hit_reg;
         sel_boot_r <= hit_boot && !hit_reg && !hit_ram;
         sel_ee_r <= hit_ee && !hit_reg && !hit_ram && !hit_boot;
         sel_rom_r <= hit_rom && !hit_reg && !hit_ram && !hit_boot && !hit_ee;
         sel_ext_r <= mda_r && !(hit_reg || hit_ram || hit_boot
                      || hit_ee || hit_rom);
      end
   end

   assign sel_regblk = sel_reg_r;
   assign sel_ram = sel_ram_r;
   assign sel_boot = sel_boot_r;
   assign sel_eeprom = sel_ee_r;
   assign sel_rom = sel_rom_r;
   assign sel_ext = sel_ext_r;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   AST_SEL_ONEHOT: assert property ($onehot0({sel_reg_r, sel_ram_r, sel_boot_r,
      sel_ee_r, sel_rom_r, sel_ext_r})) else $error("more than one select active");
   AST_REG_WINS: assert property ((a_pg == reg_pg && a_off <= REG_END) |=> sel_reg_r)
      else $error("register block not selected");
   AST_RAM_SAME: assert property ((ram_pg == reg_pg && a_pg == ram_pg
      && a_off >= RAM_SAME_LO && a_off <= ram_same_end) |=> sel_ram_r)
      else $error("RAM above register block not selected");
   AST_RAM_DIFF: assert property ((ram_pg != reg_pg && a_pg == ram_pg
      && a_off > ram_diff_end) |=> !sel_ram_r)
      else $error("RAM selected past its end");
   AST_ROM_OFF: assert property (!rom_on |=> !sel_rom_r)
      else $error("ROM selected while absent");
   AST_BOOT_GATE: assert property (sel_boot_r |-> $past(smod_r && boot_vis_r))
      else $error("boot ROM selected outside special mode");
   AST_EE_WINDOW: assert property (sel_ee_r |-> ($past(a_off) >= EE_LO
      && $past(a_pg) == $past(ee_pg) && $past(ee_on)))
      else $error("EEPROM selected outside its window");
   AST_SC_FORCE: assert property ((force_r && single_chip) |=> (rom_on && rom_hi))
      else $error("single-chip reset did not set ROM bits");
   AST_TEST_FORCE: assert property ((force_r && test_mode) |=> !rom_on)
      else $error("test reset did not clear ROM-present");
   AST_NO_EXT_SC: assert property (!mda_r |=> !sel_ext_r)
      else $error("external select in single-chip mode");
   AST_MODE_LATCH: assert property ((!rst && !latched_r) |=>
      (smod_r == $past(!mode_select_b_input) && mda_r == $past(mode_select_a_input)))
      else $error("mode pins not latched after reset");
   AST_INIT_ONCE: assert property ((init_w.wr && !smod_r && init_done)
      |=> $stable(init_q))
      else $error("placement register changed after first write");
endmodule // omd_map_decoder

// ---- sim/omd_cpu_model.sv ----
`timescale 1ns/1ps
module omd_cpu_model (
   input wire logic clk_sys,
   input wire logic rst,
   output logic [15:0] cpu_addr,
   output logic issued
);
   logic [15:0] addr_q[$];
   // ----------------------------------------
   // Address issue, toggling pattern when idle
   // ----------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cpu_addr <= 16'h0000;
         issued <= 1'b0;
      end else if (addr_q.size() > 0) begin
         cpu_addr <= addr_q.pop_front();
         issued <= 1'b1;
      end else begin
         cpu_addr <= ~cpu_addr;
         issued <= 1'b0;
      end
   end
endmodule // omd_cpu_model

// ---- sim/omd_map_decoder_tb_top.sv ----
`timescale 1ns/1ps
module omd_map_decoder_tb_top;
   import omd_pkg::*;
   logic clk_sys, rst, nv_por, mode_select_a_input, mode_select_b_input;
   logic [7:0] paddr;
   logic psel, penable, pwrite, pready, pslverr;
   logic [31:0] pwdata, prdata;
   logic [15:0] cpu_addr;
   logic issued, issued_d;
   logic sel_regblk, sel_ram, sel_boot, sel_eeprom, sel_rom, sel_ext;
   logic [27:0] sel_q[$];
   logic [16:0] rd_q[$];
   logic [27:0] e;
   logic [16:0] r;
   logic [32:0] got;
   logic [5:0] sel_s, sel_l;
   int miscompares, check_count;
   logic m_special, m_mda, m_boot, f_init, f_eeplace, f_cfg;
   logic [7:0] m_place, m_eep, m_cfg;
   localparam logic [15:0] CORNER [0:41] = '{
      16'h0000, 16'h007F, 16'h0080, 16'h02FF, 16'h0300, 16'h037F, 16'h0380, 16'h0D7F,
      16'h0D80, 16'h0FFF, 16'h1000, 16'h107F, 16'h1080, 16'h137F, 16'h2000, 16'h22FF,
      16'h2300, 16'h3000, 16'h307F, 16'h3080, 16'h337F, 16'h3380, 16'h4000, 16'h42FF,
      16'h4300, 16'h5000, 16'h507F, 16'h5080, 16'h7FFF, 16'h8000, 16'h9FFF, 16'hA000,
      16'hBD80, 16'hBDFF, 16'hBE00, 16'hBFFF, 16'hC000, 16'hFD7F, 16'hFD80, 16'hFFFF,
      16'h047F, 16'h0480};

   omd_map_decoder DUT (.clk_sys(clk_sys), .rst(rst), .nv_por(nv_por),
      .mode_select_a_input(mode_select_a_input), .mode_select_b_input(mode_select_b_input),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_addr(cpu_addr),
      .sel_regblk(sel_regblk), .sel_ram(sel_ram), .sel_boot(sel_boot),
      .sel_eeprom(sel_eeprom), .sel_rom(sel_rom), .sel_ext(sel_ext));
   omd_cpu_model cpu (.clk_sys(clk_sys), .rst(rst), .cpu_addr(cpu_addr), .issued(issued));
   // Larger variant shares every input; only its selects are compared
   omd_map_decoder #(.LARGE_VARIANT(1'b1)) DUT_LARGE (.clk_sys(clk_sys), .rst(rst),
      .nv_por(nv_por), .mode_select_a_input(mode_select_a_input),
      .mode_select_b_input(mode_select_b_input), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(),
      .pslverr(), .cpu_addr(cpu_addr), .sel_regblk(sel_l[5]), .sel_ram(sel_l[4]),
      .sel_boot(sel_l[3]), .sel_eeprom(sel_l[2]), .sel_rom(sel_l[1]), .sel_ext(sel_l[0]));
   assign sel_s = {sel_regblk, sel_ram, sel_boot, sel_eeprom, sel_rom, sel_ext};

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Expected select from the mirrored state
   // ----------------------------------------
   function automatic logic [5:0] ref_sel(input logic [15:0] a, input bit lg);
      logic [11:0] off;
      off = a[11:0];
      if (a[15:12] == m_place[3:0] && off <= REG_END) return 6'h20;
      if (a[15:12] == m_place[7:4] && ((m_place[7:4] == m_place[3:0]) ?
          (off >= RAM_SAME_LO && off <= (lg ? RAM_SAME_END_L : RAM_SAME_END_S)) :
          off <= (lg ? RAM_DIFF_END_L : RAM_DIFF_END_S))) return 6'h10;
      if (m_special && m_boot && a >= BOOT_LO && a <= BOOT_HI) return 6'h08;
      if (m_cfg[CFG_EE_ENABLE] && a[15:12] == m_eep[7:4] && off >= EE_LO) return 6'h04;
      if (m_cfg[CFG_ROM_PRESENT] && lg && a[15] == m_cfg[CFG_ROM_HIGH]) return 6'h02;
      if (m_cfg[CFG_ROM_PRESENT] && !lg && (m_cfg[CFG_ROM_HIGH] ? a >= ROM_S_HIGH_LO :
          (!m_special && m_mda && a >= ROM_S_LOW_LO && a <= ROM_S_LOW_HI))) return 6'h02;
      return {5'h00, m_mda};
   endfunction

   // ----------------------------------------
   // Result monitor
   // ----------------------------------------
   always @(posedge clk_sys) begin
      issued_d <= issued;
      if (issued_d && sel_q.size() > 0) begin
         e = sel_q.pop_front();
         check_count++;
         if (sel_s !== e[11:6]) begin
            miscompares++;
            $display("Error at %0t: addr %h select mismatch, want %h", $time, e[27:12], e[11:6]);
         end
         check_count++;
         if (sel_l !== e[5:0]) begin
            miscompares++;
            $display("Error at %0t: large addr %h want %h", $time, e[27:12], e[5:0]);
         end
      end
      if (psel && penable && pready && !pwrite && rd_q.size() > 0) begin
         r = rd_q.pop_front();
         check_count++;
         got = {pslverr, prdata & {24'hFFFFFF, r[15:8]}};
         if (got !== {r[16], 24'h000000, r[7:0] & r[15:8]}) begin
            miscompares++;
            $display("Error at %0t: read addr %h got %h", $time, paddr, prdata);
         end
      end
   end

   task automatic apb(input logic [7:0] a, input logic wr, input logic [7:0] d);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= {24'h000000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         miscompares++;
         $display("Error at %0t: no pready on addr %h", $time, a);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      apb(a, 1'b1, d);
      if (a == ADR_INIT && (m_special || !f_init)) m_place = d;
      if (a == ADR_EEPLACE && (m_special || !f_eeplace)) m_eep = d;
      if (a == ADR_CONFIG && (m_special || !f_cfg)) m_cfg = d;
      if (a == ADR_PRIO && m_special) begin
         m_boot = d[PRIO_BOOT];
         m_mda = d[PRIO_MDA];
      end
      f_init = f_init || a == ADR_INIT;
      f_eeplace = f_eeplace || a == ADR_EEPLACE;
      f_cfg = f_cfg || a == ADR_CONFIG;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic err, input logic [7:0] m, d);
      rd_q.push_back({err, m, d});
      apb(a, 1'b0, 8'h00);
   endtask

   task automatic do_reset(input logic b, input logic a);
      @(posedge clk_sys);
      rst <= 1'b1;
      mode_select_b_input <= b;
      mode_select_a_input <= a;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      nv_por <= 1'b0;
      repeat (3) @(posedge clk_sys);
      m_special = !b;
      m_mda = a;
      m_boot = !b && !a;
      m_place = INIT_RST;
      m_eep = EEPLACE_RST;
      {f_init, f_eeplace, f_cfg} = 3'h0;
      if (b && !a) m_cfg = m_cfg | 8'h0A;
      if (!b && a) m_cfg[CFG_ROM_PRESENT] = 1'b0;
   endtask

   task automatic sweep();
      logic [15:0] a;
      int n;
      foreach (CORNER[i]) begin
         cpu.addr_q.push_back(CORNER[i]);
         sel_q.push_back({CORNER[i], ref_sel(CORNER[i], 1'b0), ref_sel(CORNER[i], 1'b1)});
      end
      repeat (24) begin
         a = 16'($urandom);
         cpu.addr_q.push_back(a);
         sel_q.push_back({a, ref_sel(a, 1'b0), ref_sel(a, 1'b1)});
      end
      n = 0;
      while (sel_q.size() > 0 && n < 500) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 500) begin
         miscompares++;
         $display("Error at %0t: selects missing", $time);
      end
   endtask

   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #100us;
      miscompares++;
      $display("Error at %0t: watchdog expired", $time);
      complete_run();
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      {rst, nv_por, mode_select_b_input, mode_select_a_input} = 4'hE;
      {paddr, psel, penable, pwrite, pwdata, issued_d} = '0;
      {miscompares, check_count} = '0;
      m_cfg = CONFIG_NV_DEFAULT;
      void'($urandom(32'h8126089D));
      do_reset(1'b1, 1'b0);
      sweep();
      rd_chk(ADR_CONFIG, 1'b0, 8'h0B, m_cfg);
      rd_chk(ADR_PRIO, 1'b0, 8'hE0, 8'h00);
      rd_chk(8'h00, 1'b1, 8'hFF, 8'h00);
      $display("Test defaults done");
      wr_reg(ADR_INIT, 8'h21);
      wr_reg(ADR_INIT, 8'h00);
      wr_reg(ADR_EEPLACE, 8'hF0);
      wr_reg(ADR_EEPLACE, 8'h00);
      sweep();
      rd_chk(ADR_INIT, 1'b0, 8'hFF, 8'h21);
      rd_chk(ADR_EEPLACE, 1'b0, 8'hF0, 8'hF0);
      wr_reg(ADR_CONFIG, 8'h0A);
      wr_reg(ADR_CONFIG, 8'h0B);
      sweep();
      rd_chk(ADR_CONFIG, 1'b0, 8'h0B, 8'h0A);
      $display("Test single_chip done");
      do_reset(1'b1, 1'b1);
      rd_chk(ADR_CONFIG, 1'b0, 8'h0B, 8'h0A);
      sweep();
      wr_reg(ADR_CONFIG, 8'h03);
      sweep();
      $display("Test expanded done");
      do_reset(1'b0, 1'b1);
      rd_chk(ADR_CONFIG, 1'b0, 8'h0B, m_cfg);
      sweep();
      wr_reg(ADR_CONFIG, 8'h09);
      wr_reg(ADR_CONFIG, 8'h0B);
      wr_reg(ADR_INIT, 8'h33);
      sweep();
      wr_reg(ADR_INIT, 8'h45);
      wr_reg(ADR_EEPLACE, 8'hB0);
      wr_reg(ADR_EEPLACE, 8'h00);
      wr_reg(ADR_PRIO, 8'hE0);
      sweep();
      $display("Test special_test done");
      do_reset(1'b0, 1'b0);
      rd_chk(ADR_PRIO, 1'b0, 8'hE0, 8'hC0);
      sweep();
      $display("Test bootstrap done");
      complete_run();
   end
endmodule // omd_map_decoder_tb_top
